// [src/can_gcs_pkg.sv]
// Purpose: Constants and types of the CAN global control block
// Assumes: Byte registers, strobe port, one clock
// Notes:   Offsets are local choices
//
// Operation
// [R1] Enable command is not immediate; a read-only flag shows the mode in force.
// [R2] Standby lets current transmit finish, then freezes channel; tx recessive, rx off.
// [R3] Enable mode is entered only after 11 recessive bits are read from the bus.
// [R4] Software should abort and await receiver idle before commanding standby.
// [R5] Soft reset bit resets only the controller, ORed with hardware reset, self-clears.
// [R6] Overload-sent flag follows overload frame transmission and raises no interrupt.
// [R7] Transmitter-busy flag follows any sent frame, ack field or interframe space.
// [R8] Receiver-busy flag follows frame reception or monitoring, no interrupt.
// [R9] Bus-off and error-passive bits mirror fault state; only bus-off entry flags.
// [R10] Bus-off interrupt flag sets on passive-to-bus-off entry; write one clears.
// [R11] Summary flag is one when any source except timer wrap is pending.
// [R12] Timer-wrap flag sets on 0xFFFF-to-zero wrap; cleared by write one or handler.
// [R13] Frame-buffer-done sets on buffer completion; clear only after all configs rewritten.
// [R14] Stuff error flag sets on over five equal bits; error flags clear on write one.
// [R15] CRC, form and ack error flags set on their respective detections.
// [R16] Enable mask has master enable plus per-source enables including timer wrap.
// [R17] Fifteen read-only in-use bits 14:0 set when configured enabled; bit 15 reserved.
// [R18] In-use bit clears on tx/rx ok, disable config, abort or standby.
// [R19] Abort request clears all in-use bits; ongoing frame finishes normally.
// [R20] Writing zero to a write-one-to-clear flag leaves it unchanged.
// [R21] Reserved bits read zero, ignore writes; all registers zero on either reset.
package can_gcs_pkg;

   localparam int ADDR_W = 4;
   localparam int NUM_OBJ = 15;
   localparam int REC_BITS = 11;
   localparam int REC_CNT_W = 4;

   // Register offsets
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_IRQ_FLAGS = 4'h2;
   localparam logic [3:0] OFS_IRQ_ENABLE = 4'h3;
   localparam logic [3:0] OFS_IN_USE_LOW = 4'h4;
   localparam logic [3:0] OFS_IN_USE_HIGH = 4'h5;

   // Control register fields
   localparam int CTL_ABORT = 7;
   localparam int CTL_ENABLE = 1;
   localparam int CTL_SOFT_RESET = 0;
   localparam logic [7:0] CTL_WRITE_MASK = 8'h82;

   // Status register fields
   localparam int ST_OVERLOAD = 6;
   localparam int ST_TX_ACTIVE = 4;
   localparam int ST_RX_ACTIVE = 3;
   localparam int ST_ENABLE = 2;
   localparam int ST_BUS_OFF = 1;
   localparam int ST_ERR_PASSIVE = 0;

   // Interrupt flag fields
   localparam int IF_SUMMARY = 7;
   localparam int IF_BUS_OFF = 6;
   localparam int IF_TIMER_WRAP = 5;
   localparam int IF_BUFFER_DONE = 4;
   localparam int IF_STUFF = 3;
   localparam int IF_CRC = 2;
   localparam int IF_FORM = 1;
   localparam int IF_ACK = 0;

   // Enable mask fields
   localparam int IE_MASTER = 7;
   localparam int IE_BUS_OFF = 6;
   localparam int IE_RECEIVE = 5;
   localparam int IE_TRANSMIT = 4;
   localparam int IE_OBJ_ERROR = 3;
   localparam int IE_BUFFER = 2;
   localparam int IE_GEN_ERROR = 1;
   localparam int IE_TIMER_WRAP = 0;

   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] REC_ZERO = 4'h0;
   localparam logic [3:0] REC_ONE = 4'h1;

   typedef enum logic [1:0] {
      MODE_STANDBY = 2'b00,
      MODE_WAIT_IDLE = 2'b01,
      MODE_ENABLED = 2'b10,
      MODE_DRAIN = 2'b11
   } mode_t;

   // Engine events, one-cycle pulses unless noted
   typedef struct packed {
      logic                 bit_tick;       // Sample point of a bus bit
      logic                 bus_recessive;  // Sampled bus level at bit_tick
      logic                 tx_frame;       // Level: frame/ack/ifs being sent
      logic                 overload_tx;    // Level: overload frame being sent
      logic                 rx_frame;       // Level: frame received or monitored
      logic                 err_passive;    // Level: fault state error passive
      logic                 bus_off;        // Level: fault state bus off
      logic                 timer_wrap;
      logic                 buffer_done;
      logic                 stuff_err;
      logic                 crc_err;
      logic                 form_err;
      logic                 ack_err;
      logic                 obj_irq_pending; // Level: object rx/tx/err pending
      logic                 timer_handler_ack;
   } engine_evt_t;

   // Per-object configuration events
   typedef struct packed {
      logic [NUM_OBJ-1:0]   cfg_enable;
      logic [NUM_OBJ-1:0]   cfg_disable;
      logic [NUM_OBJ-1:0]   xfer_ok;
      logic [NUM_OBJ-1:0]   buffer_member;  // Level: object belongs to buffer
   } obj_evt_t;

   typedef struct packed {
      logic                 tx_recessive;   // Force transmitter recessive
      logic                 rx_enable;
      logic                 freeze;         // Hold object configs
      logic                 abort_pending;  // Drop pending transmissions
   } channel_ctl_t;

endpackage

// [src/can_recessive_counter.sv]
// Purpose: Counts recessive bus bits before enabling
// Assumes: bit_tick marks one sample per bus bit on ref_clk
// Notes:   Restarts at any dominant bit or when not armed
`timescale 1ns/100ps
module can_recessive_counter (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic armed,
   input  wire logic bit_tick,
   input  wire logic bus_recessive,
   output logic      seen
);

   typedef struct packed {
      logic [can_gcs_pkg::REC_CNT_W-1:0] count;
      logic                              seen;
   } state_t;

   state_t st;
   state_t next_st;

   // A dominant bit restarts the idle run
   always_comb begin
      next_st = st;
      if (!armed) begin
         next_st.count = can_gcs_pkg::REC_ZERO;
         next_st.seen = 1'b0;
      end else if (bit_tick) begin
         if (!bus_recessive) begin
            next_st.count = can_gcs_pkg::REC_ZERO;
         end else if (st.count != can_gcs_pkg::REC_BITS[3:0]) begin
            next_st.count = st.count + can_gcs_pkg::REC_ONE;
         end
         next_st.seen = bus_recessive &&
            (st.count == can_gcs_pkg::REC_BITS[3:0] - can_gcs_pkg::REC_ONE ||
             st.count == can_gcs_pkg::REC_BITS[3:0]); // [R3]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign seen = st.seen;

endmodule

// [src/can_global_control_status_irq.sv]
// Purpose: Global control, status and interrupt flags of the CAN controller
// Assumes: Engine events synchronous to ref_clk
// Notes:   Controller reset is rst ORed with soft reset
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
module can_global_control_status_irq (
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   input  wire logic [can_gcs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [7:0]                  reg_rdata,
   input  can_gcs_pkg::engine_evt_t         engine_evt,
   input  can_gcs_pkg::obj_evt_t            obj_evt,
   output can_gcs_pkg::channel_ctl_t        channel_ctl,
   output logic                             ctrl_reset,
   output logic                             irq_general,
   output logic                             irq_timer_wrap
);

   typedef struct packed {
      can_gcs_pkg::mode_t                mode;
      logic                              enable_standby_cmd;
      logic                              abort_request;
      logic                              soft_reset_req;
      logic [7:0]                        status;
      logic [6:0]                        flags;
      logic [7:0]                        irq_enable;
      logic [can_gcs_pkg::NUM_OBJ-1:0]   in_use;
      logic [can_gcs_pkg::NUM_OBJ-1:0]   rewritten;
      logic                              prev_err_passive;
      logic [7:0]                        rdata;
      can_gcs_pkg::channel_ctl_t         ctl;
      logic                              irq_general;
      logic                              irq_timer_wrap;
   } state_t;

   state_t st;
   state_t next_st;
   logic   ctl_rst;
   logic   rec_seen;
   logic   summary;
   logic   wr_ctl;
   logic   wr_flags;
   logic   wr_ie;

   ////////////////////////////////////////////////////////////////////////////
   // Register access decode

   // True when this cycle writes the given offset
   function automatic logic wr_hit(input logic [can_gcs_pkg::ADDR_W-1:0] a);
      return reg_wr && (reg_addr == a);
   endfunction

   assign wr_ctl = wr_hit(can_gcs_pkg::OFS_CONTROL);
   assign wr_flags = wr_hit(can_gcs_pkg::OFS_IRQ_FLAGS);
   assign wr_ie = wr_hit(can_gcs_pkg::OFS_IRQ_ENABLE);

   // Soft reset from a flop, so the reset is glitch free
   assign ctl_rst = rst || st.soft_reset_req; // [R5]

   ////////////////////////////////////////////////////////////////////////////
   // Idle detector for leaving standby

   can_recessive_counter u_rec (
      .ref_clk       (ref_clk),
      .rst           (ctl_rst),
      .armed         (st.mode == can_gcs_pkg::MODE_WAIT_IDLE),
      .bit_tick      (engine_evt.bit_tick),
      .bus_recessive (engine_evt.bus_recessive),
      .seen          (rec_seen)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pending summary for polling, timer wrap excluded

   always_comb begin
      summary = st.flags[can_gcs_pkg::IF_BUS_OFF] ||
                st.flags[can_gcs_pkg::IF_BUFFER_DONE] ||
                st.flags[can_gcs_pkg::IF_STUFF] ||
                st.flags[can_gcs_pkg::IF_CRC] ||
                st.flags[can_gcs_pkg::IF_FORM] ||
                st.flags[can_gcs_pkg::IF_ACK] ||
                engine_evt.obj_irq_pending; // [R11]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      next_st = st;
      next_st.soft_reset_req = 1'b0; // [R5]

      // Control writes; other bits are dropped
      if (wr_ctl) begin
         next_st.abort_request = reg_wdata[can_gcs_pkg::CTL_ABORT];
         next_st.enable_standby_cmd = reg_wdata[can_gcs_pkg::CTL_ENABLE]; // [R1]
         next_st.soft_reset_req = reg_wdata[can_gcs_pkg::CTL_SOFT_RESET]; // [R5]
      end

      // The command only requests; the mode follows the bus
      unique case (st.mode)
         can_gcs_pkg::MODE_STANDBY: begin
            if (st.enable_standby_cmd) begin
               next_st.mode = can_gcs_pkg::MODE_WAIT_IDLE; // [R1]
            end
         end
         can_gcs_pkg::MODE_WAIT_IDLE: begin
            if (!st.enable_standby_cmd) begin
               next_st.mode = can_gcs_pkg::MODE_STANDBY;
            end else if (rec_seen) begin
               next_st.mode = can_gcs_pkg::MODE_ENABLED; // [R3]
            end
         end
         can_gcs_pkg::MODE_ENABLED: begin
            if (!st.enable_standby_cmd) begin
               next_st.mode = can_gcs_pkg::MODE_DRAIN; // [R2]
            end
         end
         can_gcs_pkg::MODE_DRAIN: begin
            // Let the ongoing frame end before the freeze
            if (!engine_evt.tx_frame) begin
               next_st.mode = can_gcs_pkg::MODE_STANDBY; // [R2]
            end
         end
      endcase

      // Channel control; standby during reception is software's hazard
      next_st.ctl.rx_enable = (next_st.mode == can_gcs_pkg::MODE_ENABLED); // [R2] [R4]
      next_st.ctl.tx_recessive = (next_st.mode == can_gcs_pkg::MODE_STANDBY) ||
                                 (next_st.mode == can_gcs_pkg::MODE_WAIT_IDLE); // [R2]
      next_st.ctl.freeze = next_st.ctl.tx_recessive; // [R2]
      next_st.ctl.abort_pending = next_st.abort_request; // [R19]

      // Status mirrors engine levels, raising no interrupt
      next_st.status = can_gcs_pkg::BYTE_ZERO; // [R21]
      next_st.status[can_gcs_pkg::ST_OVERLOAD] = engine_evt.overload_tx; // [R6]
      next_st.status[can_gcs_pkg::ST_TX_ACTIVE] = engine_evt.tx_frame; // [R7]
      next_st.status[can_gcs_pkg::ST_RX_ACTIVE] = engine_evt.rx_frame; // [R8]
      next_st.status[can_gcs_pkg::ST_ENABLE] =
         (next_st.mode == can_gcs_pkg::MODE_ENABLED) ||
         (next_st.mode == can_gcs_pkg::MODE_DRAIN); // [R1]
      next_st.status[can_gcs_pkg::ST_BUS_OFF] = engine_evt.bus_off; // [R9]
      next_st.status[can_gcs_pkg::ST_ERR_PASSIVE] = engine_evt.err_passive; // [R9]
      next_st.prev_err_passive = engine_evt.err_passive;

      // Buffer objects whose config was rewritten
      next_st.rewritten = st.rewritten |
                          ((obj_evt.cfg_enable | obj_evt.cfg_disable) &
                           obj_evt.buffer_member); // [R13]

      // Write-one-to-clear; zero bits leave flags alone
      if (wr_flags) begin
         if (reg_wdata[can_gcs_pkg::IF_BUS_OFF]) begin
            next_st.flags[can_gcs_pkg::IF_BUS_OFF] = 1'b0; // [R10] [R20]
         end
         if (reg_wdata[can_gcs_pkg::IF_TIMER_WRAP]) begin
            next_st.flags[can_gcs_pkg::IF_TIMER_WRAP] = 1'b0; // [R12] [R20]
         end
         if (reg_wdata[can_gcs_pkg::IF_BUFFER_DONE] &&
             ((st.rewritten & obj_evt.buffer_member) == obj_evt.buffer_member)) begin
            next_st.flags[can_gcs_pkg::IF_BUFFER_DONE] = 1'b0; // [R13]
            next_st.rewritten = '0;
         end
         for (int i = can_gcs_pkg::IF_ACK; i <= can_gcs_pkg::IF_STUFF; i++) begin
            if (reg_wdata[i]) begin
               next_st.flags[i] = 1'b0; // [R14] [R20]
            end
         end
      end
      if (engine_evt.timer_handler_ack) begin
         next_st.flags[can_gcs_pkg::IF_TIMER_WRAP] = 1'b0; // [R12]
      end

      // Sets come last so an event beats a same-cycle clear
      if (engine_evt.bus_off && !st.status[can_gcs_pkg::ST_BUS_OFF] &&
          st.prev_err_passive) begin
         next_st.flags[can_gcs_pkg::IF_BUS_OFF] = 1'b1; // [R9] [R10]
      end
      if (engine_evt.timer_wrap) begin
         next_st.flags[can_gcs_pkg::IF_TIMER_WRAP] = 1'b1; // [R12]
      end
      if (engine_evt.buffer_done) begin
         next_st.flags[can_gcs_pkg::IF_BUFFER_DONE] = 1'b1; // [R13]
      end
      if (engine_evt.stuff_err) begin
         next_st.flags[can_gcs_pkg::IF_STUFF] = 1'b1; // [R14]
      end
      if (engine_evt.crc_err) begin
         next_st.flags[can_gcs_pkg::IF_CRC] = 1'b1; // [R15]
      end
      if (engine_evt.form_err) begin
         next_st.flags[can_gcs_pkg::IF_FORM] = 1'b1; // [R15]
      end
      if (engine_evt.ack_err) begin
         next_st.flags[can_gcs_pkg::IF_ACK] = 1'b1; // [R15]
      end

      if (wr_ie) begin
         next_st.irq_enable = reg_wdata; // [R16]
      end

      // In-use bits: clears dominate; abort and standby clear all
      next_st.in_use = (st.in_use | obj_evt.cfg_enable) &
                       ~obj_evt.cfg_disable & ~obj_evt.xfer_ok; // [R17] [R18]
      if (next_st.abort_request || next_st.ctl.freeze) begin
         next_st.in_use = '0; // [R18] [R19]
      end

      // Interrupt lines gated by the mask
      next_st.irq_general = st.irq_enable[can_gcs_pkg::IE_MASTER] && (
         (st.irq_enable[can_gcs_pkg::IE_BUS_OFF] &&
          st.flags[can_gcs_pkg::IF_BUS_OFF]) ||
         (st.irq_enable[can_gcs_pkg::IE_BUFFER] &&
          st.flags[can_gcs_pkg::IF_BUFFER_DONE]) ||
         (st.irq_enable[can_gcs_pkg::IE_GEN_ERROR] &&
          (|st.flags[can_gcs_pkg::IF_STUFF:can_gcs_pkg::IF_ACK])) ||
         ((st.irq_enable[can_gcs_pkg::IE_RECEIVE] ||
           st.irq_enable[can_gcs_pkg::IE_TRANSMIT] ||
           st.irq_enable[can_gcs_pkg::IE_OBJ_ERROR]) &&
          engine_evt.obj_irq_pending)); // [R16]
      next_st.irq_timer_wrap = st.irq_enable[can_gcs_pkg::IE_TIMER_WRAP] &&
                               st.flags[can_gcs_pkg::IF_TIMER_WRAP]; // [R16]

      // Read data one cycle after the strobe; unmapped reads give zero
      next_st.rdata = can_gcs_pkg::BYTE_ZERO;
      if (reg_rd) begin
         unique case (reg_addr)
            can_gcs_pkg::OFS_CONTROL: begin
               next_st.rdata[can_gcs_pkg::CTL_ABORT] = st.abort_request;
               next_st.rdata[can_gcs_pkg::CTL_ENABLE] = st.enable_standby_cmd;
            end
            can_gcs_pkg::OFS_STATUS: begin
               next_st.rdata = st.status;
            end
            can_gcs_pkg::OFS_IRQ_FLAGS: begin
               next_st.rdata = {summary, st.flags}; // [R11]
            end
            can_gcs_pkg::OFS_IRQ_ENABLE: begin
               next_st.rdata = st.irq_enable;
            end
            can_gcs_pkg::OFS_IN_USE_LOW: begin
               next_st.rdata = st.in_use[7:0]; // [R17]
            end
            can_gcs_pkg::OFS_IN_USE_HIGH: begin
               next_st.rdata = {1'b0, st.in_use[can_gcs_pkg::NUM_OBJ-1:8]}; // [R21]
            end
            default: begin
               next_st.rdata = can_gcs_pkg::BYTE_ZERO;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; soft reset clears its own request

   always_ff @(posedge ref_clk) begin
      if (ctl_rst) begin
         st <= '0; // [R21]
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign reg_rdata = st.rdata;
   assign channel_ctl = st.ctl;
   assign ctrl_reset = st.soft_reset_req;
   assign irq_general = st.irq_general;
   assign irq_timer_wrap = st.irq_timer_wrap;

endmodule

// [bench/can_bus_partner.sv]
// Purpose: Other nodes: bus bit samples and frame activity
// Assumes: One bit per BIT_CYC clocks; dom sends dominant
// Notes:   Level toggles off the sample point
`timescale 1ns/100ps
module can_bus_partner #(
   parameter int BIT_CYC = 4
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic dom,
   output logic      bit_tick,
   output logic      bus_recessive,
   output logic      rx_frame
);
   logic [3:0] phase;
   ////////////////////////////////////////
   // Bit sampler
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase         <= 4'h0;
         bit_tick      <= 1'b0;
         bus_recessive <= 1'b1;
      end else begin
         phase         <= (phase == 4'(BIT_CYC - 1)) ? 4'h0 : phase + 4'h1;
         bit_tick      <= (phase == 4'h0);
         bus_recessive <= (phase == 4'h0) ? !dom : !bus_recessive;
      end
   end
   // A sending node is a frame to monitor
   assign rx_frame = dom;
endmodule

// [bench/can_global_control_status_irq_asserts.sv]
// Purpose: Port assertions for the CAN global control block
// Assumes: Enable mask is shadowed from bus writes
// Notes:   Soft reset disables properties like rst, except the two soft reset checks
`timescale 1ns/100ps
module can_gcs_checker (
   input  wire logic                           ref_clk,
   input  wire logic                           rst,
   input  wire logic [can_gcs_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                     reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   input  wire logic [7:0]                     reg_rdata,
   input  can_gcs_pkg::engine_evt_t            engine_evt,
   input  can_gcs_pkg::obj_evt_t               obj_evt,
   input  can_gcs_pkg::channel_ctl_t           channel_ctl,
   input  wire logic                           ctrl_reset,
   input  wire logic                           irq_general,
   input  wire logic                           irq_timer_wrap
);
   localparam int REC_NEED = 11;
   logic [7:0] ie_sh;
   logic [3:0] rec_cnt;
   logic       wr_ie;
   ////////////////////////////////////////
   // Mask shadow; saturating recessive run
   assign wr_ie = reg_wr && reg_addr == can_gcs_pkg::OFS_IRQ_ENABLE;
   always_ff @(posedge ref_clk) begin
      if (rst || ctrl_reset) begin
         ie_sh   <= 8'h00;
         rec_cnt <= 4'h0;
      end else begin
         if (wr_ie) begin
            ie_sh <= reg_wdata;
         end
         if (engine_evt.bit_tick) begin
            rec_cnt <= !engine_evt.bus_recessive ? 4'h0 :
                       (rec_cnt == 4'hF) ? rec_cnt : rec_cnt + 4'h1;
         end
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst || ctrl_reset);
   ////////////////////////////////////////
   // Properties
   soft_reset_pulse_a: assert property (disable iff (rst)
      reg_wr && reg_addr == can_gcs_pkg::OFS_CONTROL && reg_wdata[0] |=> ctrl_reset ##1 !ctrl_reset)
      else $error("soft reset pulse wrong");
   soft_reset_clear_a: assert property (disable iff (rst)
      ctrl_reset |=> !irq_general && !irq_timer_wrap) else $error("soft reset left irq");
   status_mirror_a: assert property (reg_rd && reg_addr == can_gcs_pkg::OFS_STATUS |=>
      reg_rdata == {1'b0, $past(engine_evt.overload_tx, 2), 1'b0, $past(engine_evt.tx_frame, 2),
      $past(engine_evt.rx_frame, 2), reg_rdata[2], $past(engine_evt.bus_off, 2),
      $past(engine_evt.err_passive, 2)}) else $error("status read wrong");
   unmapped_read_a: assert property (reg_rd && reg_addr > can_gcs_pkg::OFS_IN_USE_HIGH
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   timer_irq_set_a: assert property (engine_evt.timer_wrap && ie_sh[0] && !wr_ie
      |-> ##2 irq_timer_wrap) else $error("timer irq missing");
   handler_clear_a: assert property ((engine_evt.timer_handler_ack && !engine_evt.timer_wrap)
      ##1 !engine_evt.timer_wrap |=> !irq_timer_wrap) else $error("handler did not clear");
   summary_mask_a: assert property (irq_general |-> $past(ie_sh[7]))
      else $error("irq without master enable");
   bus_off_irq_a: assert property ($rose(engine_evt.bus_off) && $past(engine_evt.err_passive)
      && ie_sh[7] && ie_sh[6] |-> ##[2:3] irq_general) else $error("bus off irq missing");
   enable_wait_a: assert property ($rose(channel_ctl.rx_enable) |-> rec_cnt >= REC_NEED)
      else $error("enabled too early");
   standby_freeze_a: assert property (channel_ctl.freeze
      |-> channel_ctl.tx_recessive && !channel_ctl.rx_enable) else $error("standby not frozen");
   cover property (ctrl_reset);
   cover property ($rose(irq_general));
   cover property ($rose(channel_ctl.rx_enable));
endmodule

bind can_global_control_status_irq can_gcs_checker u_gcs_chk (.*);

// [bench/can_global_control_status_irq_tb.sv]
// Purpose: Bench for the CAN global control block
// Assumes: Partner drives bus bits
// Notes:   Flag cases from a table
`timescale 1ns/100ps
module can_global_control_status_irq_tb;
   typedef struct packed {
      logic [5:0] ev;
      logic [7:0] fl;
   } row_t;
   logic                      ref_clk;
   logic                      rst;
   logic [3:0]                reg_addr;
   logic [7:0]                reg_wdata;
   logic                      reg_wr;
   logic                      reg_rd;
   logic [7:0]                reg_rdata;
   can_gcs_pkg::engine_evt_t  engine_evt;
   can_gcs_pkg::obj_evt_t     obj_evt;
   can_gcs_pkg::channel_ctl_t channel_ctl;
   logic                      ctrl_reset;
   logic                      irq_general;
   logic                      irq_timer_wrap;
   logic                      p_tick, p_rec, rx_f, dom, tx_f, ovl, ep, bo, hack, opnd;
   logic [5:0]                ev;
   int                        errors;
   int                        check_count;
   row_t                      rows [6] = '{'{6'h20, 8'h20}, '{6'h10, 8'h90}, '{6'h08, 8'h88},
                                           '{6'h04, 8'h84}, '{6'h02, 8'h82}, '{6'h01, 8'h81}};
   assign engine_evt = {p_tick, p_rec, tx_f, ovl, rx_f, ep, bo, ev, opnd, hack};
   can_global_control_status_irq DUT (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .engine_evt, .obj_evt, .channel_ctl, .ctrl_reset, .irq_general,
      .irq_timer_wrap);
   can_bus_partner far_node (.ref_clk, .rst, .dom, .bit_tick(p_tick), .bus_recessive(p_rec),
      .rx_frame(rx_f));
   ////////////////////////////////////////
   // Helpers
   task automatic report_and_stop();
      if (errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge ref_clk iff p_tick);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   task automatic epulse(input logic [5:0] v);
      @(posedge ref_clk);
      ev <= v;
      @(posedge ref_clk);
      ev <= 6'h00;
   endtask
   task automatic opulse(input can_gcs_pkg::obj_evt_t o);
      @(posedge ref_clk);
      obj_evt <= o;
      @(posedge ref_clk);
      obj_evt <= '0;
   endtask
   ////////////////////////////////////////
   // Clock; watchdog far beyond the run length
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      errors++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      {rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 4'h0, 8'h00, 2'b00};
      {dom, tx_f, ovl, ep, bo, hack, opnd, ev} = 13'h0000;
      obj_evt = '0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) rd(4'(a), 8'h00);
      foreach (rows[i]) begin
         epulse(rows[i].ev);
         rd(4'h2, rows[i].fl);
         wr(4'h2, 8'h00);
         rd(4'h2, rows[i].fl);
         wr(4'h2, rows[i].fl);
         rd(4'h2, 8'h00);
      end
      // Bus off flags only from error passive
      wr(4'h3, 8'hC1);
      ep <= 1'b1;
      step(2);
      rd(4'h1, 8'h01);
      ep <= 1'b0;
      bo <= 1'b1;
      step(3);
      rd(4'h1, 8'h02);
      rd(4'h2, 8'hC0);
      chk({7'h00, irq_general}, 8'h01);
      wr(4'h2, 8'h40);
      rd(4'h2, 8'h00);
      bo <= 1'b0;
      step(2);
      bo <= 1'b1;
      step(3);
      rd(4'h2, 8'h00);
      bo <= 1'b0;
      // Timer wrap: own enable, not in summary
      epulse(6'h20);
      step(2);
      chk({7'h00, irq_timer_wrap}, 8'h01);
      chk({7'h00, irq_general}, 8'h00);
      hack <= 1'b1;
      step(1);
      hack <= 1'b0;
      step(3);
      chk({7'h00, irq_timer_wrap}, 8'h00);
      rd(4'h2, 8'h00);
      // Busy levels raise nothing
      {tx_f, ovl, dom} <= 3'b111;
      step(3);
      rd(4'h1, 8'h58);
      rd(4'h2, 8'h00);
      chk({7'h00, irq_general}, 8'h00);
      {tx_f, ovl} <= 2'b00;
      // Enable waits for a run of recessive bits
      wr(4'h0, 8'h02);
      ticks(3);
      rd(4'h1, 8'h08);
      dom <= 1'b0;
      ticks(9);
      rd(4'h1, 8'h00);
      ticks(3);
      step(3);
      rd(4'h1, 8'h04);
      // Object in-use bits, abort and standby
      opulse({15'h4001, 45'h0});
      rd(4'h4, 8'h01);
      rd(4'h5, 8'h40);
      opulse({30'h0, 15'h0001, 15'h0});
      rd(4'h4, 8'h00);
      opulse({15'h0, 15'h4000, 30'h0});
      rd(4'h5, 8'h00);
      opulse({15'h0008, 45'h0});
      wr(4'h0, 8'h82);
      rd(4'h4, 8'h00);
      rd(4'h0, 8'h82);
      wr(4'h0, 8'h02);
      opulse({15'h0020, 45'h0});
      rd(4'h4, 8'h20);
      tx_f <= 1'b1;
      wr(4'h0, 8'h00);
      step(4);
      rd(4'h1, 8'h14);
      tx_f <= 1'b0;
      step(4);
      rd(4'h1, 8'h00);
      rd(4'h4, 8'h00);
      chk({4'h0, channel_ctl}, 8'h0A);
      opnd <= 1'b1;
      step(3);
      rd(4'h2, 8'h80);
      chk({7'h00, irq_general}, 8'h00);
      wr(4'h3, 8'hA0);
      step(2);
      chk({7'h00, irq_general}, 8'h01);
      opnd <= 1'b0;
      // Soft reset clears mask and itself
      wr(4'h3, 8'hFF);
      wr(4'h0, 8'h01);
      step(2);
      rd(4'h3, 8'h00);
      rd(4'h0, 8'h00);
      report_and_stop();
   end
endmodule
